// ---- core/adcc_top.sv ----
// converter control: start handshake, sequencer, power, pins, apb registers
`default_nettype none
module adcc_top #(
    // conversion length in conversion clock periods; the counter holds up to 32
    parameter int CONV_PERIODS = adcc_pkg::CONV_PERIODS
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [7:0] port_direction_reg_in,
    input wire logic [7:0] port_pullup_in,
    input wire logic [11:0] sar_result_in,
    output logic analog_power_out,
    output logic converter_reset_out,
    output logic sample_strobe_out,
    output logic [7:0] analog_pin_enable_out,
    output logic [2:0] channel_select_out,
    output logic [7:0] port_direction_out,
    output logic [7:0] port_pullup_out,
    output logic irq_out
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] clock_select;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic global_irq_enable;
        logic converter_irq_enable;
        logic start_prev;
        adcc_pkg::adcc_state_t seq;
        logic [4:0] period_count;
        logic [11:0] result;
        logic [31:0] rdata;
    } adcc_top_state_t;

    adcc_top_state_t state;
    adcc_top_state_t next_state;
    logic rst_sync_1;
    logic rst_n;
    logic conv_tick;
    logic start_bit;
    logic [2:0] pin_select;
    logic powered;
    logic wr;
    logic rd;
    logic mapped;
    logic done_event;
    logic [7:0] wbyte;

    // the period counter is five bits wide
    if (CONV_PERIODS < 1 || CONV_PERIODS > 32) begin : g_bad_periods
        $error("conversion length does not fit the period counter");
    end

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync_1 <= 1'b1;
            rst_n <= rst_sync_1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign start_bit = state.control[adcc_pkg::CTRL_START_BIT];
    assign pin_select = state.control[adcc_pkg::CTRL_PIN_SEL_LSB +: 3];
    // either method turns the analog side off on its own
    assign powered = (pin_select != 3'h0)
        && !state.clock_select[adcc_pkg::CSEL_DISABLE_BIT];
    assign wr = psel_in && penable_in && pwrite_in;
    assign rd = psel_in && !penable_in && !pwrite_in;
    assign wbyte = pwdata_in[7:0];
    assign mapped = paddr_in == adcc_pkg::ADDR_CONTROL
        || paddr_in == adcc_pkg::ADDR_CLOCK_SELECT
        || paddr_in == adcc_pkg::ADDR_IRQ_STATUS
        || paddr_in == adcc_pkg::ADDR_IRQ_MASK
        || paddr_in == adcc_pkg::ADDR_IRQ_CONTROL
        || paddr_in == adcc_pkg::ADDR_RESULT_LOW
        || paddr_in == adcc_pkg::ADDR_RESULT_HIGH;

    adcc_divider u_divider (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .run_in(state.seq == adcc_pkg::ADCC_CONVERT && powered),
        .div_select_in(state.clock_select[adcc_pkg::CSEL_DIV_LSB +: 3]),
        .tick_out(conv_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        done_event = 1'b0;
        next_state.start_prev = start_bit;
        // sequencer
        case (state.seq)
            adcc_pkg::ADCC_IDLE: begin
                if (start_bit) begin
                    next_state.seq = adcc_pkg::ADCC_HELD;
                end
            end
            adcc_pkg::ADCC_HELD: begin
                next_state.period_count = 5'h00;
                // the falling edge after a high phase is the trigger
                if (state.start_prev && !start_bit) begin
                    next_state.seq = adcc_pkg::ADCC_CONVERT;
                end
            end
            adcc_pkg::ADCC_CONVERT: begin
                if (start_bit) begin
                    next_state.seq = adcc_pkg::ADCC_HELD;
                end else if (!powered) begin
                    // powered off mid-conversion abandons it, flag stays high
                    next_state.seq = adcc_pkg::ADCC_IDLE;
                end else if (conv_tick) begin
                    if (state.period_count == 5'(CONV_PERIODS - 1)) begin
                        next_state.seq = adcc_pkg::ADCC_IDLE;
                        done_event = 1'b1;
                    end else begin
                        next_state.period_count = state.period_count + 5'h01;
                    end
                end
            end
            default: next_state.seq = adcc_pkg::ADCC_IDLE;
        endcase

        // apb writes
        if (wr) begin
            case (paddr_in)
                adcc_pkg::ADDR_CONTROL: begin
                    next_state.control[adcc_pkg::CTRL_START_BIT] = wbyte[adcc_pkg::CTRL_START_BIT];
                    next_state.control[5:0] = wbyte[5:0];
                end
                adcc_pkg::ADDR_CLOCK_SELECT: next_state.clock_select = wbyte;
                adcc_pkg::ADDR_IRQ_STATUS: next_state.irq_status = state.irq_status & ~wbyte[1:0];
                adcc_pkg::ADDR_IRQ_MASK: next_state.irq_mask = wbyte[1:0];
                adcc_pkg::ADDR_IRQ_CONTROL: begin
                    next_state.global_irq_enable = wbyte[adcc_pkg::ICTL_GLOBAL_BIT];
                    next_state.converter_irq_enable = wbyte[adcc_pkg::ICTL_CONV_BIT];
                    if (!wbyte[adcc_pkg::ICTL_REQ_BIT]) begin
                        next_state.irq_status[0] = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // done flag: held high while start high, cleared by hardware at end
        if (start_bit || next_state.control[adcc_pkg::CTRL_START_BIT]) begin
            next_state.control[adcc_pkg::CTRL_DONE_N_BIT] = 1'b1;
        end else if (done_event) begin
            next_state.control[adcc_pkg::CTRL_DONE_N_BIT] = 1'b0;
        end
        // status bit 0: conversion complete request, bit 1: power dropped mid conversion
        if (done_event) begin
            next_state.irq_status[0] = 1'b1;
            next_state.result = sar_result_in;
        end
        if (state.seq == adcc_pkg::ADCC_CONVERT && !powered && !start_bit) begin
            next_state.irq_status[1] = 1'b1;
        end

        // apb read data captured in setup so it comes from a flop
        if (rd) begin
            case (paddr_in)
                adcc_pkg::ADDR_CONTROL: next_state.rdata = {24'h000000, state.control};
                adcc_pkg::ADDR_CLOCK_SELECT: next_state.rdata = {24'h000000, state.clock_select};
                adcc_pkg::ADDR_IRQ_STATUS: next_state.rdata = {30'h00000000, state.irq_status};
                adcc_pkg::ADDR_IRQ_MASK: next_state.rdata = {30'h00000000, state.irq_mask};
                adcc_pkg::ADDR_IRQ_CONTROL: next_state.rdata = {29'h00000000,
                    state.irq_status[0], state.converter_irq_enable, state.global_irq_enable};
                adcc_pkg::ADDR_RESULT_LOW: next_state.rdata = {24'h000000, state.result[7:0]};
                adcc_pkg::ADDR_RESULT_HIGH: next_state.rdata = {28'h0000000, state.result[11:8]};
                default: next_state.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.control <= adcc_pkg::CONTROL_RESET;
            state.clock_select <= adcc_pkg::CLOCK_SELECT_RESET;
            state.seq <= adcc_pkg::ADCC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin routing and outputs
    genvar pin;
    generate
        for (pin = 0; pin < 8; pin++) begin : g_pin
            // code 111 takes all eight, n takes the lowest n
            assign analog_pin_enable_out[pin] = (pin_select == adcc_pkg::PIN_SEL_ALL)
                || (3'(pin) < pin_select);
            // analog pins force input and drop the pull-up
            assign port_direction_out[pin] = analog_pin_enable_out[pin]
                ? 1'b1 : port_direction_reg_in[pin];
            assign port_pullup_out[pin] = port_pullup_in[pin]
                && !analog_pin_enable_out[pin];
        end
    endgenerate

    assign channel_select_out = state.control[adcc_pkg::CTRL_CHAN_LSB +: 3];
    assign analog_power_out = powered;
    // start high resets at once, not a cycle later through the sequencer
    assign converter_reset_out = (state.seq != adcc_pkg::ADCC_CONVERT)
        || start_bit;
    assign sample_strobe_out = conv_tick;
    // both enables needed, plus the mask of the status register
    assign irq_out = |(state.irq_status & state.irq_mask) && state.global_irq_enable
        && state.converter_irq_enable;
    assign prdata_out = state.rdata;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;
endmodule
`default_nettype wire

// ---- core/adcc_pkg.sv ----
// package of constants and types for the converter control block
`default_nettype none
package adcc_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h14;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h18;
    // converter_control fields
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_DONE_N_BIT = 6;
    localparam int CTRL_PIN_SEL_LSB = 3;
    localparam int CTRL_CHAN_LSB = 0;
    // converter_clock_select fields
    localparam int CSEL_DISABLE_BIT = 7;
    localparam int CSEL_DIV_LSB = 0;
    // interrupt_control_reg fields
    localparam int ICTL_GLOBAL_BIT = 0;
    localparam int ICTL_CONV_BIT = 1;
    localparam int ICTL_REQ_BIT = 2;
    localparam logic [7:0] CONTROL_RESET = 8'h40;
    localparam logic [7:0] CLOCK_SELECT_RESET = 8'h81;
    localparam logic [2:0] DIV_CODE_2 = 3'h0;
    localparam logic [2:0] DIV_CODE_8 = 3'h1;
    localparam logic [2:0] DIV_CODE_32 = 3'h2;
    localparam logic [2:0] PIN_SEL_ALL = 3'h7;
    localparam int DIV_2 = 2;
    localparam int DIV_8 = 8;
    localparam int DIV_32 = 32;
    localparam int CONV_PERIODS = 16;
    localparam int RESULT_WIDTH = 12;
    typedef enum logic [1:0] {ADCC_IDLE, ADCC_HELD, ADCC_CONVERT} adcc_state_t;
endpackage
`default_nettype wire

// ---- core/adcc_divider.sv ----
// conversion clock enable divider
`default_nettype none
module adcc_divider (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic [2:0] div_select_in,
    output logic tick_out
);
    typedef struct packed {
        logic [4:0] count;
        logic tick;
    } adcc_div_state_t;
    adcc_div_state_t state;
    adcc_div_state_t next_state;
    logic [5:0] ratio;

    always_comb begin
        case (div_select_in)
            adcc_pkg::DIV_CODE_2: ratio = 6'(adcc_pkg::DIV_2);
            adcc_pkg::DIV_CODE_8: ratio = 6'(adcc_pkg::DIV_8);
            adcc_pkg::DIV_CODE_32: ratio = 6'(adcc_pkg::DIV_32);
            default: ratio = 6'h00; // undefined codes give no clock
        endcase
    end

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (!run_in || ratio == 6'h00) begin
            next_state.count = 5'h00;
        end else if ({1'b0, state.count} == ratio - 6'h01) begin
            next_state.count = 5'h00;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 5'h01;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick_out = state.tick;
endmodule
`default_nettype wire

// ---- verif/adcc_props.sv ----
// port checker for the converter control block
`default_nettype none
module adcc_props (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [7:0] port_direction_reg_in,
    input wire logic [7:0] port_pullup_in,
    input wire logic analog_power_out,
    input wire logic converter_reset_out,
    input wire logic sample_strobe_out,
    input wire logic [7:0] analog_pin_enable_out,
    input wire logic [2:0] channel_select_out,
    input wire logic [7:0] port_direction_out,
    input wire logic [7:0] port_pullup_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////
    logic wc;
    logic [2:0] h;
    logic [4:0] cnt;
    assign wc = psel_in & penable_in & pwrite_in & (paddr_in == adcc_pkg::ADDR_CONTROL);
    // h remembers recent start-low writes; cnt counts ticks of one conversion
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            h <= 3'h0;
            cnt <= 5'h00;
        end else begin
            h <= {h[1:0], wc & ~pwdata_in[7]};
            cnt <= converter_reset_out ? 5'h00 : cnt + 5'(sample_strobe_out);
        end
    end
    ////////////////////////////////////////////////////////////////
    AST_HOLD: assert property (wc && pwdata_in[7] |=> converter_reset_out)
        else $error("converter not held while start high");
    AST_LAUNCH: assert property (
        $fell(converter_reset_out) |-> h != 3'h0 && analog_power_out)
        else $error("conversion began without a start pulse");
    AST_TICKS: assert property (cnt <= 5'h10)
        else $error("conversion ran past sixteen ticks");
    AST_STROBE: assert property (sample_strobe_out |=> !sample_strobe_out)
        else $error("conversion tick faster than half the clock");
    AST_CHAN: assert property (
        wc |=> channel_select_out == $past(pwdata_in[2:0]))
        else $error("channel select not taken from write");
    AST_PULL: assert property (
        port_pullup_out == (port_pullup_in & ~analog_pin_enable_out))
        else $error("pull-up not dropped on analog pin");
    AST_DIR: assert property (
        port_direction_out == (port_direction_reg_in | analog_pin_enable_out))
        else $error("direction not overridden on analog pin");
    AST_MASK: assert property (
        analog_pin_enable_out inside {8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'hFF})
        else $error("analog pins not a low contiguous group");
    AST_OFF: assert property (
        analog_pin_enable_out == 8'h00 |-> !analog_power_out)
        else $error("analog powered with no pins selected");
    cover property ($fell(converter_reset_out));
    cover property (cnt == 5'h10);
    cover property (wc && pwdata_in[7]);
endmodule
bind adcc_top adcc_props u_props (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .port_direction_reg_in(port_direction_reg_in),
    .port_pullup_in(port_pullup_in),
    .analog_power_out(analog_power_out),
    .converter_reset_out(converter_reset_out),
    .sample_strobe_out(sample_strobe_out),
    .analog_pin_enable_out(analog_pin_enable_out),
    .channel_select_out(channel_select_out),
    .port_direction_out(port_direction_out),
    .port_pullup_out(port_pullup_out)
);
`default_nettype wire

// ---- verif/adcc_analog_model.sv ----
// behavioural analog front end feeding the result port
`default_nettype none
module adcc_analog_model (
    input wire logic clock_in,
    input wire logic converter_reset_out,
    input wire logic [2:0] channel_select_out,
    output logic [11:0] sar_result_in
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////
    initial sar_result_in = 12'h000;
    // outside a conversion the value churns, so a late capture shows
    always @(posedge clock_in) begin
        if (converter_reset_out) begin
            sar_result_in <= ~sar_result_in;
        end else begin
            sar_result_in <= {channel_select_out, 9'h0A5};
        end
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the converter control block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00, port_direction_reg_in = 8'hA5, port_pullup_in = 8'h5A;
    logic [31:0] pwdata_in = 32'h0, prdata_out, v;
    logic pready_out, pslverr_out, analog_power_out, converter_reset_out, sample_strobe_out;
    logic irq_out, e;
    logic [11:0] sar_result_in;
    logic [7:0] analog_pin_enable_out, port_direction_out, port_pullup_out;
    logic [2:0] channel_select_out;
    logic [7:0] m;
    int n_errors = 0, total_checks = 0, cyc = 0, t, dv;
    adcc_top dut (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .port_direction_reg_in(port_direction_reg_in),
        .port_pullup_in(port_pullup_in),
        .sar_result_in(sar_result_in),
        .analog_power_out(analog_power_out),
        .converter_reset_out(converter_reset_out),
        .sample_strobe_out(sample_strobe_out),
        .analog_pin_enable_out(analog_pin_enable_out),
        .channel_select_out(channel_select_out),
        .port_direction_out(port_direction_out),
        .port_pullup_out(port_pullup_out),
        .irq_out(irq_out)
    );
    adcc_analog_model model (
        .clock_in(clock_in),
        .converter_reset_out(converter_reset_out),
        .channel_select_out(channel_select_out),
        .sar_result_in(sar_result_in)
    );
    ////////////////////////////////////////////////////////////////
    initial forever #12.5 clock_in = ~clock_in;
    always @(posedge clock_in) cyc <= cyc + 1;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        v = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        total_checks++;
        if (s !== x) begin
            $display("wrong value %s expected %h seen %h", n, x, s);
            n_errors++;
        end
    endtask
    task automatic settle;
        @(posedge clock_in);
        #1;
    endtask
    task automatic end_sim;
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock_in);
        n_errors++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        xfer(1'b0, adcc_pkg::ADDR_CONTROL, 32'h0);
        chk("control reset", 32'(adcc_pkg::CONTROL_RESET), v);
        xfer(1'b0, adcc_pkg::ADDR_CLOCK_SELECT, 32'h0);
        chk("clock select reset", 32'(adcc_pkg::CLOCK_SELECT_RESET), v);
        xfer(1'b0, 8'h1C, 32'h0);
        chk("unmapped error", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, v);
        xfer(1'b1, adcc_pkg::ADDR_CLOCK_SELECT, 32'h1);
        for (int p = 0; p < 8; p++) begin
            xfer(1'b1, adcc_pkg::ADDR_CONTROL, 32'(p << 3));
            settle;
            m = (p == 7) ? 8'hFF : 8'((1 << p) - 1);
            chk("pins", 32'(m), 32'(analog_pin_enable_out));
            chk("dir", 32'(port_direction_reg_in | m), 32'(port_direction_out));
            chk("pullup", 32'(port_pullup_in & ~m), 32'(port_pullup_out));
            chk("power", 32'(p != 0), 32'(analog_power_out));
        end
        xfer(1'b1, adcc_pkg::ADDR_CLOCK_SELECT, 32'h81);
        settle;
        chk("power disabled", 32'h0, 32'(analog_power_out));
        for (int d = 0; d < 3; d++) begin
            // the ideal model has no minimum period, so divide by 2 gets the same timing, irq and result checks as the others
            xfer(1'b1, adcc_pkg::ADDR_CLOCK_SELECT, 32'(d));
            xfer(1'b1, adcc_pkg::ADDR_IRQ_MASK, 32'(d != 1));
            xfer(1'b1, adcc_pkg::ADDR_IRQ_CONTROL, 32'h3);
            // pins and start written together, read back, then start dropped by the next control write
            xfer(1'b1, adcc_pkg::ADDR_CONTROL, 32'(8'hB8 + d + 5));
            xfer(1'b0, adcc_pkg::ADDR_CONTROL, 32'h0);
            chk("done flag while start high", 32'h1, 32'(v[6]));
            chk("converter held", 32'h1, 32'(converter_reset_out));
            xfer(1'b1, adcc_pkg::ADDR_CONTROL, 32'(8'h38 + d + 5));
            t = cyc;
            do begin
                xfer(1'b0, adcc_pkg::ADDR_CONTROL, 32'h0);
            end while (v[6] !== 1'b0);
            dv = 2 << (2 * d);
            e = (cyc - t >= 16 * dv) && (cyc - t <= 16 * dv + 10);
            chk("conversion time", 32'h1, 32'(e));
            settle;
            chk("irq", 32'(d != 1), 32'(irq_out));
            xfer(1'b0, adcc_pkg::ADDR_IRQ_STATUS, 32'h0);
            chk("status", 32'h1, v);
            xfer(1'b0, adcc_pkg::ADDR_RESULT_LOW, 32'h0);
            chk("result low", 32'hA5, v);
            xfer(1'b0, adcc_pkg::ADDR_RESULT_HIGH, 32'h0);
            chk("result high", 32'((d + 5) << 1), v);
            xfer(1'b1, adcc_pkg::ADDR_IRQ_STATUS, 32'h1);
            settle;
            chk("irq cleared", 32'h0, 32'(irq_out));
        end
        xfer(1'b0, adcc_pkg::ADDR_IRQ_CONTROL, 32'h0);
        chk("interrupt control", 32'h3, v);
        // undefined divider code gives no tick, so the conversion never ends
        xfer(1'b1, adcc_pkg::ADDR_CLOCK_SELECT, 32'h3);
        xfer(1'b1, adcc_pkg::ADDR_CONTROL, 32'hB8);
        xfer(1'b1, adcc_pkg::ADDR_CONTROL, 32'h38);
        repeat (40) @(posedge clock_in);
        xfer(1'b0, adcc_pkg::ADDR_CONTROL, 32'h0);
        chk("no tick, no end", 32'h1, 32'(v[6]));
        chk("still converting", 32'h0, 32'(converter_reset_out));
        // clearing the pins cuts power and needs no restart
        xfer(1'b1, adcc_pkg::ADDR_CONTROL, 32'h0);
        settle;
        chk("pins released", 32'h0, 32'(analog_pin_enable_out));
        xfer(1'b0, adcc_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk("abort status", 32'h2, v);
        xfer(1'b0, adcc_pkg::ADDR_CONTROL, 32'h0);
        chk("flag after abort", 32'h40, v);
        end_sim;
    end
endmodule
`default_nettype wire
